// ---- spf_pkg.sv ----
// Constants for the shared pin function select block
package spf_pkg;

    // Shared pin count and pin positions in every pin vector
    localparam int unsigned NUM_PINS     = 13;
    localparam int unsigned PIN_EDGE1    = 0;
    localparam int unsigned PIN_EDGE2    = 1;
    localparam int unsigned PIN_EDGE3    = 2;
    localparam int unsigned PIN_EDGE4    = 3;
    localparam int unsigned PIN_FLAG     = 4;
    localparam int unsigned PIN_BRANCH   = 5;
    localparam int unsigned PIN_SYSTEM_CLOCK_PIN   = 6;
    localparam int unsigned PIN_SCI_TX   = 7;
    localparam int unsigned PIN_SCI_RX   = 8;
    localparam int unsigned PIN_SPI_MOSI = 9;
    localparam int unsigned PIN_SPI_MISO = 10;
    localparam int unsigned PIN_SPI_CLK  = 11;
    localparam int unsigned PIN_SPI_STE  = 12;

    // Pins whose peripheral function is input only
    localparam logic [12:0] PERIPH_IN_ONLY = 13'h012f;

    // Register byte offsets
    localparam logic [7:0] OFS_SEL    = 8'h00;
    localparam logic [7:0] OFS_DIR    = 8'h04;
    localparam logic [7:0] OFS_DOUT   = 8'h08;
    localparam logic [7:0] OFS_DIN    = 8'h0c;
    localparam logic [7:0] OFS_CTRL   = 8'h10;
    localparam logic [7:0] OFS_SYSCTL = 8'h14;
    localparam logic [7:0] OFS_ACTION = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // Reset values
    localparam logic [12:0] SEL_RST    = 13'h0030;
    localparam logic        CLKSEL_POR = 1'b1;
    localparam logic [12:0] DIR_RST    = 13'h0000;
    localparam logic [12:0] DOUT_RST   = 13'h0000;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic        UNMASK_RST = 1'b1;
    localparam logic [1:0]  CSRC_RST   = 2'h0;

    // Control register fields
    localparam int unsigned CTRL_FLAG   = 0;
    localparam int unsigned CTRL_UNMASK = 1;

    // Status register fields
    localparam int unsigned STAT_FLOAT  = 0;
    localparam int unsigned STAT_PDP    = 1;
    localparam int unsigned STAT_BRANCH = 2;

    // Per-output action field codes
    typedef enum logic [1:0] {
        SPF_ACT_LOW  = 2'b00,
        SPF_ACT_INVL = 2'b01,
        SPF_ACT_HIGH = 2'b10,
        SPF_ACT_ONE  = 2'b11
    } spf_action_t;

endpackage : spf_pkg

// ---- spf_shared_pins.sv ----
// Shared pin function select with compare output float control
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module spf_shared_pins
    import spf_pkg::*;
#(
    parameter int unsigned NUM_CMP = 5
) (
    // Clock and resets
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic                  por_b,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Shared pins
    input  wire logic [spf_pkg::NUM_PINS-1:0] pin_in,
    output logic [spf_pkg::NUM_PINS-1:0]      pin_out,
    output logic [spf_pkg::NUM_PINS-1:0]      pin_oe_b,
    // Peripheral side of the shared pins
    input  wire logic [spf_pkg::NUM_PINS-1:0] periph_dout,
    input  wire logic [spf_pkg::NUM_PINS-1:0] periph_drive,
    output logic [spf_pkg::NUM_PINS-1:0]      periph_din,
    // Clock candidates for the clock output pin
    input  wire logic [3:0]            clock_candidates,
    // Branch condition
    input  wire logic                  branch_on_low_instruction,
    output logic                       branch_taken,
    // Full compare outputs
    input  wire logic [NUM_CMP-1:0]    cmp_pwm,
    input  wire logic                  power_drive_protect_irq_b,
    output logic [NUM_CMP-1:0]         full_compare_out,
    output logic [NUM_CMP-1:0]         full_compare_oe_b
);

    import spf_pkg::*;

    if (NUM_CMP < 1 || NUM_CMP > 16) begin : g_chk
        $error("NUM_CMP must lie between 1 and 16");
    end

    localparam int unsigned NP = NUM_PINS;
    localparam int unsigned AW = 2 * NUM_CMP;

    // POR and external reset both clear the general state
    logic rst_all_b;
    assign rst_all_b = rst_b & por_b;

    logic [NP-1:0] sel_q;
    logic [NP-1:0] dir_q;
    logic [NP-1:0] dout_q;
    logic [NP-1:0] pin_s2_q;
    logic          flag_q;
    logic          unmask_q;
    logic [1:0]    csrc_q;
    logic [AW-1:0] action_q;
    logic          pdp_s2_q;
    logic          branch_taken_q;
    logic [31:0]   prdata_q;
    logic          clksel_q;

    // APB decode
    logic        setup;
    logic        wr_en;
    logic        hit;
    logic [31:0] wmask;
    logic [31:0] rd_d;
    logic [31:0] status_w;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        hit = 1'b1;
        case (paddr)
            OFS_SEL, OFS_DIR, OFS_DOUT, OFS_DIN,
            OFS_CTRL, OFS_SYSCTL, OFS_ACTION, OFS_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Zero wait states; error only on an unmapped word
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_q;

    // Pin synchronisers; pins idle low, protect input idles high
    spf_sync2 #(
        .WIDTH    (NP),
        .RST_VAL  (1'b0)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_all_b),
        .async_in (pin_in),
        .sync_q   (pin_s2_q)
    );

    spf_sync2 #(
        .WIDTH    (1),
        .RST_VAL  (1'b1)
    ) u_pdp_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_all_b),
        .async_in (power_drive_protect_irq_b),
        .sync_q   (pdp_s2_q)
    );

    // Full value for the select vector, clock pin bit held apart
    logic [NP-1:0] sel_full;
    always_comb begin
        sel_full             = sel_q;
        sel_full[PIN_SYSTEM_CLOCK_PIN] = clksel_q;
    end

    // Select bits: every reset picks input, flag and branch functions
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            sel_q <= SEL_RST;
        end else if (wr_en && paddr == OFS_SEL) begin
            sel_q <= (sel_q & ~wmask[NP-1:0])
                   | (pwdata[NP-1:0] & wmask[NP-1:0]);
        end
    end

    // Clock pin select survives the pin reset; only POR loads its reset value
    always_ff @(posedge sys_clk or negedge por_b) begin
        if (!por_b) begin
            clksel_q <= CLKSEL_POR;
        end else if (wr_en && paddr == OFS_SEL && pstrb[0]) begin
            clksel_q <= pwdata[PIN_SYSTEM_CLOCK_PIN];
        end
    end

    // Direction and output latches for general I/O mode
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            dir_q  <= DIR_RST;
            dout_q <= DOUT_RST;
        end else if (wr_en && paddr == OFS_DIR) begin
            dir_q <= (dir_q & ~wmask[NP-1:0])
                   | (pwdata[NP-1:0] & wmask[NP-1:0]);
        end else if (wr_en && paddr == OFS_DOUT) begin
            dout_q <= (dout_q & ~wmask[NP-1:0])
                    | (pwdata[NP-1:0] & wmask[NP-1:0]);
        end
    end

    // Flag latch and protection mask
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            flag_q   <= FLAG_RST;
            unmask_q <= UNMASK_RST;
        end else if (wr_en && paddr == OFS_CTRL && pstrb[0]) begin
            flag_q   <= pwdata[CTRL_FLAG];
            unmask_q <= pwdata[CTRL_UNMASK];
        end
    end

    // Clock source field
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            csrc_q <= CSRC_RST;
        end else if (wr_en && paddr == OFS_SYSCTL && pstrb[0]) begin
            csrc_q <= pwdata[1:0];
        end
    end

    // Compare action fields
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            action_q <= '0;
        end else if (wr_en && paddr == OFS_ACTION) begin
            action_q <= (action_q & ~wmask[AW-1:0])
                      | (pwdata[AW-1:0] & wmask[AW-1:0]);
        end
    end

    // Peripheral side values, with block-owned functions folded in
    logic [NP-1:0] periph_val;
    logic [NP-1:0] periph_en;
    logic [NP-1:0] drive;
    always_comb begin
        periph_val             = periph_dout;
        periph_en              = periph_drive & ~PERIPH_IN_ONLY;
        periph_val[PIN_FLAG]   = flag_q;
        periph_en[PIN_FLAG]    = 1'b1;
        periph_val[PIN_SYSTEM_CLOCK_PIN] = clock_candidates[csrc_q];
        periph_en[PIN_SYSTEM_CLOCK_PIN]  = 1'b1;
    end

    // Per-pin mux: select bit picks peripheral or general I/O
    for (genvar p = 0; p < NP; p++) begin : g_pin
        spf_pin_mux u_mux (
            .periph_sel (sel_full[p]),
            .periph_en  (periph_en[p]),
            .periph_val (periph_val[p]),
            .io_dir     (dir_q[p]),
            .io_dout    (dout_q[p]),
            .pin_drive  (drive[p]),
            .pin_level  (pin_out[p])
        );
    end
    assign pin_oe_b   = ~drive;
    assign periph_din = pin_s2_q;

    // Branch taken one cycle after the instruction polls a low pin
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            branch_taken_q <= 1'b0;
        end else begin
            branch_taken_q <= branch_on_low_instruction
                            & sel_full[PIN_BRANCH]
                            & ~pin_s2_q[PIN_BRANCH];
        end
    end
    assign branch_taken = branch_taken_q;

    // Float path is combinational from the pins and unmask_q, so an unmasked fault
    // tristates the drivers even with the clock stopped
    logic float_now;
    assign float_now = ~rst_b | ~por_b
                     | (unmask_q & ~power_drive_protect_irq_b);

    // Compare outputs shaped by their action field
    logic [NUM_CMP-1:0] cmp_lvl;
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            case (spf_action_t'(action_q[2*i +: 2]))
                SPF_ACT_LOW:  cmp_lvl[i] = 1'b0;
                SPF_ACT_INVL: cmp_lvl[i] = ~cmp_pwm[i];
                SPF_ACT_HIGH: cmp_lvl[i] = cmp_pwm[i];
                SPF_ACT_ONE:  cmp_lvl[i] = 1'b1;
                default:      cmp_lvl[i] = 1'b0;
            endcase
        end
    end
    assign full_compare_out  = cmp_lvl;
    assign full_compare_oe_b = {NUM_CMP{float_now}};

    // Status word
    always_comb begin
        status_w              = '0;
        status_w[STAT_FLOAT]  = float_now;
        status_w[STAT_PDP]    = pdp_s2_q;
        status_w[STAT_BRANCH] = pin_s2_q[PIN_BRANCH];
    end

    // Read mux
    always_comb begin
        rd_d = '0;
        case (paddr)
            OFS_SEL:    rd_d[NP-1:0] = sel_full;
            OFS_DIR:    rd_d[NP-1:0] = dir_q;
            OFS_DOUT:   rd_d[NP-1:0] = dout_q;
            OFS_DIN:    rd_d[NP-1:0] = pin_s2_q;
            OFS_CTRL:   rd_d[1:0]    = {unmask_q, flag_q};
            OFS_SYSCTL: rd_d[1:0]    = csrc_q;
            OFS_ACTION: rd_d[AW-1:0] = action_q;
            OFS_STATUS: rd_d         = status_w;
            default:    rd_d         = '0;
        endcase
    end

    // Read data captured in the setup cycle, stable through access
    always_ff @(posedge sys_clk or negedge rst_all_b) begin
        if (!rst_all_b) begin
            prdata_q <= '0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

endmodule : spf_shared_pins

// Two-stage synchroniser for signals from outside the clock domain
module spf_sync2 #(
    parameter int unsigned WIDTH   = 1,
    parameter logic        RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);

    if (WIDTH < 1) begin : g_chk
        $error("WIDTH must be at least 1");
    end

    // Only the second stage is read, so metastability stays here
    logic [WIDTH-1:0] s1_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q   <= {WIDTH{RST_VAL}};
            sync_q <= {WIDTH{RST_VAL}};
        end else begin
            s1_q   <= async_in;
            sync_q <= s1_q;
        end
    end

endmodule : spf_sync2

// One shared pin: peripheral function or general I/O
module spf_pin_mux (
    // Peripheral function
    input  wire logic periph_sel,
    input  wire logic periph_en,
    input  wire logic periph_val,
    // General I/O latches
    input  wire logic io_dir,
    input  wire logic io_dout,
    // Pin side
    output logic      pin_drive,
    output logic      pin_level
);

    // One select steers enable and level, so sources never mix
    assign pin_drive = periph_sel ? periph_en : io_dir;
    assign pin_level = periph_sel ? periph_val : io_dout;

endmodule : spf_pin_mux

// ---- spf_checker.sv ----
// Port-level assertions for the shared pin block
`timescale 1ns/1ps
module spf_checker
    import spf_pkg::*;
#(
    parameter int unsigned NUM_CMP = 5
) (
    // Clock and resets
    input wire logic                sys_clk,
    input wire logic                rst_b,
    input wire logic                por_b,
    // Bus
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    // Pins
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_b,
    input wire logic [NUM_PINS-1:0] periph_din,
    input wire logic [3:0]          clock_candidates,
    input wire logic                branch_on_low_instruction,
    input wire logic                branch_taken,
    input wire logic [NUM_CMP-1:0]  full_compare_oe_b
);
    wire        live = rst_b & por_b;
    logic [1:0] up_q;
    // Holds off the sync check until stale reset history is flushed
    always_ff @(posedge sys_clk or negedge live) begin
        if (!live) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!live);
    float_on_reset_a: assert property (disable iff (!por_b)
        !rst_b |-> &full_compare_oe_b) else $error("compare pins driven");
    float_group_a: assert property (
        full_compare_oe_b == '0 || &full_compare_oe_b)
        else $error("compare pins float apart");
    branch_pulse_a: assert property (
        branch_taken |-> $past(branch_on_low_instruction)
            && pin_oe_b[PIN_BRANCH]) else $error("stray branch");
    bus_ready_a: assert property (psel && penable |-> pready)
        else $error("no ready");
    bus_error_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
    input_sync_a: assert property (
        up_q == 2'h3 |-> periph_din == $past(pin_in, 2))
        else $error("input sync latency");
    reset_pins_a: assert property (
        $rose(live) |-> (pin_oe_b | 13'h0040) == 13'h1fef
            && !pin_out[PIN_FLAG]) else $error("pin reset defaults");
    por_clock_a: assert property (
        $rose(live) && !$past(por_b) |-> !pin_oe_b[PIN_SYSTEM_CLOCK_PIN]
            && pin_out[PIN_SYSTEM_CLOCK_PIN] == clock_candidates[0])
        else $error("clock pin after power-on");
endmodule : spf_checker

// ---- spf_board.sv ----
// Board model: pull-ups and optional external drivers on the shared pins
`timescale 1ns/1ps
module spf_board
    import spf_pkg::*;
(
    // Device side
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe_b,
    // Board drivers
    input  wire logic [NUM_PINS-1:0] ext_val,
    input  wire logic [NUM_PINS-1:0] ext_en,
    // Resolved levels
    output logic [NUM_PINS-1:0]      pin_in
);
    // Undriven pins sit high, as an unused branch pin must
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!pin_oe_b[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else pin_in[i] = 1'b1;
        end
    end
endmodule : spf_board

// ---- shared_pin_function_select_test.sv ----
// Self-checking bench for the shared pin function select block
`timescale 1ns/1ps
module shared_pin_function_select_test;
    import spf_pkg::*;
    typedef struct {logic [9:0] act; logic [4:0] pwm, exp;} spf_row_t;
    logic                sys_clk = 0, rst_b = 0, por_b = 0, instr = 0;
    logic                psel = 0, penable = 0, pwrite = 0, pdp_b = 1;
    logic [7:0]          paddr = '0;
    logic [31:0]         pwdata = '0, prdata, rd;
    logic                pready, pslverr, err, branch_taken;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_b, pdin;
    logic [NUM_PINS-1:0] pdout = '0, pdrv = '0, ext_val = '0, ext_en = '0;
    logic [3:0]          cand = 4'h6;
    logic [4:0]          pwm = '0, cmp_out, cmp_oe_b;
    int                  bad_count = 0, total_checks = 0;
    spf_row_t            rows [5] = '{'{10'h000, 5'h15, 5'h00},
        '{10'h155, 5'h15, 5'h0a}, '{10'h2aa, 5'h15, 5'h15},
        '{10'h3ff, 5'h15, 5'h1f}, '{10'h0e4, 5'h1f, 5'h0c}};
    always #2.5 sys_clk = ~sys_clk;
    spf_shared_pins uut (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_b(pin_oe_b), .periph_dout(pdout), .periph_drive(pdrv),
        .periph_din(pdin), .clock_candidates(cand),
        .branch_on_low_instruction(instr), .branch_taken(branch_taken),
        .cmp_pwm(pwm), .power_drive_protect_irq_b(pdp_b),
        .full_compare_out(cmp_out), .full_compare_oe_b(cmp_oe_b));
    spf_board board (.pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic branch(input logic lvl, input logic exp);
        ext_val[PIN_BRANCH] <= lvl;
        repeat (3) @(posedge sys_clk);
        instr <= 1'b1;
        @(posedge sys_clk);
        instr <= 1'b0;
        @(negedge sys_clk);
        check(branch_taken, exp);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(branch_taken, 1'b0);
        @(posedge sys_clk);
    endtask : branch
    initial begin
        repeat (4) @(posedge sys_clk);
        check(cmp_oe_b, 5'h1f);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge sys_clk);
        apb(0, OFS_SEL, '0);
        check(rd, 32'h70);
        apb(0, OFS_DIR, '0);
        check(rd, 32'h0);
        apb(0, OFS_CTRL, '0);
        check(rd, 32'h2);
        apb(0, 8'h20, '0);
        check(err, 1'b1);
        foreach (rows[i]) begin
            pwm <= rows[i].pwm;
            apb(1, OFS_ACTION, {22'h0, rows[i].act});
            check(cmp_out, rows[i].exp);
            check(cmp_oe_b, 5'h0);
        end
        for (int s = 0; s < 4; s++) begin
            apb(1, OFS_SYSCTL, 32'(s));
            check(pin_out[PIN_SYSTEM_CLOCK_PIN], cand[s]);
        end
        apb(1, OFS_CTRL, 32'h3);
        check(pin_out[PIN_FLAG], 1'b1);
        apb(1, OFS_DIR, 32'h1);
        apb(1, OFS_DOUT, 32'h1);
        check({pin_oe_b[0], pin_out[0]}, 2'b01);
        ext_en <= 13'h0120;
        repeat (3) @(posedge sys_clk);
        apb(0, OFS_DIN, '0);
        check(rd[PIN_SCI_RX], 1'b0);
        check(pdin[PIN_SCI_RX], 1'b0);
        pdrv  <= 13'h1e80;
        pdout <= 13'h1e80;
        apb(1, OFS_SEL, 32'h1ff0);
        check(pin_oe_b & 13'h1e80, 13'h0);
        check(pin_out & 13'h1e80, 13'h1e80);
        branch(1'b0, 1'b1);
        branch(1'b1, 1'b0);
        apb(1, OFS_SEL, 32'h0);
        branch(1'b0, 1'b0);
        apb(1, OFS_ACTION, 32'h3ff);
        pdp_b <= 1'b0;
        #1;
        check(cmp_oe_b, 5'h1f);
        repeat (3) @(posedge sys_clk);
        apb(0, OFS_STATUS, '0);
        check(rd, 32'h1);
        apb(1, OFS_CTRL, 32'h1);
        check({cmp_oe_b, cmp_out}, 10'h01f);
        rst_b <= 1'b0;
        #1;
        check(cmp_oe_b, 5'h1f);
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        apb(0, OFS_SEL, '0);
        check(rd, 32'h30);
        report_and_stop();
    end
endmodule : shared_pin_function_select_test
bind spf_shared_pins spf_checker #(.NUM_CMP(NUM_CMP)) chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .periph_din(periph_din), .clock_candidates(clock_candidates),
    .branch_on_low_instruction(branch_on_low_instruction),
    .branch_taken(branch_taken), .full_compare_oe_b(full_compare_oe_b));
